// File: rtl/rfc_defs.svh
/*
  rfc_defs.svh: register indices, field positions, write masks and
  reset values of the rf frontend control register bank.
  assumes: included by the bank module; the bank package does not include it.
*/
`ifndef RFC_DEFS_SVH
`define RFC_DEFS_SVH

// register indices; byte address is index times four
`define RFC_TX_IDX 8'h20
`define RFC_CK_IDX 8'h21
`define RFC_RX_IDX 8'h22

// reset values of the three registers
`define RFC_TX_RST 32'h0000_0000
`define RFC_CK_RST 32'h0000_0000
`define RFC_RX_RST 32'h0000_0000

// writable bits of each register
`define RFC_TX_MASK 32'h07ff_ffff
`define RFC_CK_MASK 32'h0004_3fff
`define RFC_RX_MASK 32'h0000_00ff

// transmit register fields
`define RFC_TX_DRV 26
`define RFC_TX_AMP 24
`define RFC_TX_PRS 19
`define RFC_TX_MAX 18
`define RFC_TX_RES 13
`define RFC_TX_BYP 12
`define RFC_TX_SLW 8
`define RFC_TX_TFL 4
`define RFC_TX_TRS 0

// clock register fields
`define RFC_CK_ALM 18
`define RFC_CK_PH 11
`define RFC_CK_PRV 8
`define RFC_CK_I2R 7
`define RFC_CK_I2C 6
`define RFC_CK_I1R 5
`define RFC_CK_I1C 4
`define RFC_CK_RMD 1
`define RFC_CK_PLL 0

// receive register fields
`define RFC_RX_MIL 6
`define RFC_RX_MIX 4
`define RFC_RX_HPC 2
`define RFC_RX_GN 0

// mixer control codes that enable one mixer
`define RFC_MIX_RD 2'h1
`define RFC_MIX_CD 2'h2

`endif

// File: rtl/rfc_pkg.sv
/*
  rfc_pkg.sv: types of the rf frontend control register bank.
  assumes: nothing beyond the header of constants.
*/
package rfc_pkg;

  // transmit register, bits 26..0 in printed order
  typedef struct packed {
    logic drv_single;
    logic [1:0] card_amp;
    logic [4:0] prev_resid;
    logic card_max;
    logic [4:0] resid;
    logic bypass;
    logic [3:0] slew;
    logic [3:0] tau_fall;
    logic [3:0] tau_rise;
  } rfc_tx_t;

  // clock register, reserved bits left out
  typedef struct packed {
    logic active_load_modulation;
    logic [2:0] phase;
    logic [2:0] prev_mode;
    logic inv2_rd;
    logic inv2_cd;
    logic inv1_rd;
    logic inv1_cd;
    logic [2:0] rd_mode;
    logic pll;
  } rfc_ck_t;

  // receive register, bits 7..0
  typedef struct packed {
    logic [1:0] miller;
    logic [1:0] mixer;
    logic [1:0] hpc;
    logic [1:0] gain;
  } rfc_rx_t;

  // operating mode from the frontend sequencer
  typedef struct packed {
    logic card_mode;
    logic prevention;
    logic single_pump;
  } rfc_mode_t;

  // settings that drive the analog transmitter
  typedef struct packed {
    logic single_driver;
    logic [1:0] card_amp;
    logic card_max;
    logic [4:0] residual;
    logic shaping_bypass;
    logic [3:0] slew;
    logic [3:0] fall_tau;
    logic fall_tau_en;
    logic [3:0] rise_tau;
    logic rise_tau_en;
    logic active_loadmod;
    logic [2:0] phase;
    logic [2:0] clk_mode;
    logic out1_invert;
    logic out2_invert;
    logic pll_enable;
  } rfc_txdrv_t;

  // settings that drive the analog receiver
  typedef struct packed {
    logic mixer_reader_en;
    logic mixer_card_en;
    logic [1:0] hpc;
    logic [1:0] gain;
    logic [1:0] miller;
  } rfc_rxdrv_t;

  // whole state of the bank
  typedef struct packed {
    rfc_tx_t tx;
    rfc_ck_t ck;
    rfc_rx_t rx;
    logic [31:0] rdata;
    rfc_txdrv_t txd;
    rfc_rxdrv_t rxd;
  } rfc_state_t;

endpackage : rfc_pkg

// File: rtl/rfc_regs.sv
/*
  rfc_regs.sv: transmit, transmit clock and receive control
  registers of a contactless rf frontend, decoded into the
  settings that steer the analog transmitter and receiver.
  assumes: one 100 MHz clock; mode inputs come from logic on the
  same clock; the register master keeps strobes one cycle long.
*/
//////////////////////////////////////////////////////////////////
// Functional notes
// - driver select bit: clear uses both drivers, set one.
// - two-bit field sets card mode carrier amplitude.
// - prevention residual carrier used only during prevention.
// - max output bit forces pump maximum, overriding amplitude.
// - residual code 0 is 100 percent carrier, 1f zero.
// - shaping bypass disables rising edge time constant.
// - four-bit slew for both edges, 0 slowest, f fastest.
// - edge time constants act only in single pump mode.
// - load modulation enable selects active modulation in card.
// - three-bit phase offset in 45 degree steps.
// - three-bit clock mode used only during prevention.
// - reader mode: invert bits pick inverted carrier clock.
// - card mode: invert bits pick inverted carrier clock.
// - reader clock mode field selects transmitter drive option.
// - mixer code 01 reader, 10 card, others both off.
// - two-bit high-pass corner selects one of four.
// - two-bit baseband gain, reset to code zero.
// - two-bit Miller demodulator reference level.
//////////////////////////////////////////////////////////////////
`include "rfc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module rfc_regs (
  input wire logic i_clk_sys, // 100 MHz system clock
  input wire logic i_reset, // async reset, active high
  input wire logic [9:0] i_addr, // byte address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire rfc_pkg::rfc_mode_t i_mode, // operating mode
  output logic [31:0] o_rdata, // read data, cycle after read
  output var rfc_pkg::rfc_txdrv_t o_tx, // transmitter settings
  output var rfc_pkg::rfc_rxdrv_t o_rx // receiver settings
);

  //////////////////////////////////////////////////////////////////
  // address decode

  localparam logic [9:0] TX_ADDR = {`RFC_TX_IDX, 2'h0};
  localparam logic [9:0] CK_ADDR = {`RFC_CK_IDX, 2'h0};
  localparam logic [9:0] RX_ADDR = {`RFC_RX_IDX, 2'h0};

  rfc_pkg::rfc_state_t st_q;
  rfc_pkg::rfc_state_t st_d;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] ck_word;

  // readback image of the clock register
  assign ck_word = {13'h0, st_q.ck.active_load_modulation, 4'h0,
                    st_q.ck.phase, st_q.ck.prev_mode,
                    st_q.ck.inv2_rd, st_q.ck.inv2_cd,
                    st_q.ck.inv1_rd, st_q.ck.inv1_cd,
                    st_q.ck.rd_mode, st_q.ck.pll};

  // write data with reserved bits forced low
  always_comb begin
    unique case (i_addr)
      TX_ADDR: wmask = `RFC_TX_MASK;
      CK_ADDR: wmask = `RFC_CK_MASK;
      RX_ADDR: wmask = `RFC_RX_MASK;
      default: wmask = 32'h0000_0000;
    endcase
    wval = i_wdata & wmask;
  end

  //////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    st_d.rdata = 32'h0000_0000;

    // register writes; unmapped addresses are dropped
    if (i_wr) begin
      unique case (i_addr)
        TX_ADDR: begin
          st_d.tx = rfc_pkg::rfc_tx_t'(wval[26:0]);
        end
        CK_ADDR: begin
          st_d.ck.active_load_modulation = wval[`RFC_CK_ALM];
          st_d.ck.phase = wval[`RFC_CK_PH +: 3];
          st_d.ck.prev_mode = wval[`RFC_CK_PRV +: 3];
          st_d.ck.inv2_rd = wval[`RFC_CK_I2R];
          st_d.ck.inv2_cd = wval[`RFC_CK_I2C];
          st_d.ck.inv1_rd = wval[`RFC_CK_I1R];
          st_d.ck.inv1_cd = wval[`RFC_CK_I1C];
          st_d.ck.rd_mode = wval[`RFC_CK_RMD +: 3];
          st_d.ck.pll = wval[`RFC_CK_PLL];
        end
        RX_ADDR: begin
          st_d.rx = rfc_pkg::rfc_rx_t'(wval[7:0]);
        end
        default: begin
        end
      endcase
    end

    // register reads; unmapped addresses read zero
    if (i_rd) begin
      unique case (i_addr)
        TX_ADDR: st_d.rdata = {5'h0, st_q.tx};
        CK_ADDR: st_d.rdata = ck_word;
        RX_ADDR: st_d.rdata = {24'h0, st_q.rx};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end

    // transmitter driver and amplitude
    st_d.txd.single_driver = st_d.tx.drv_single;
    st_d.txd.card_max = st_d.tx.card_max;
    // pump maximum overrides the amplitude code
    st_d.txd.card_amp = st_d.tx.card_max ? 2'h0
                        : st_d.tx.card_amp;

    // residual code passes unchanged: 0 full, 1f none
    st_d.txd.residual = i_mode.prevention
                        ? st_d.tx.prev_resid
                        : st_d.tx.resid;

    // edge shaping
    st_d.txd.shaping_bypass = st_d.tx.bypass;
    st_d.txd.slew = st_d.tx.slew;
    st_d.txd.fall_tau = st_d.tx.tau_fall;
    st_d.txd.fall_tau_en = i_mode.single_pump;
    st_d.txd.rise_tau = st_d.tx.tau_rise;
    st_d.txd.rise_tau_en = i_mode.single_pump
                           & ~st_d.tx.bypass;

    // load modulation and clock path
    st_d.txd.active_loadmod = i_mode.card_mode
                              & st_d.ck.active_load_modulation;
    st_d.txd.phase = st_d.ck.phase;
    st_d.txd.clk_mode = i_mode.prevention
                        ? st_d.ck.prev_mode
                        : st_d.ck.rd_mode;
    st_d.txd.out1_invert = i_mode.card_mode
                           ? st_d.ck.inv1_cd
                           : st_d.ck.inv1_rd;
    st_d.txd.out2_invert = i_mode.card_mode
                           ? st_d.ck.inv2_cd
                           : st_d.ck.inv2_rd;
    st_d.txd.pll_enable = st_d.ck.pll;

    // receiver chain
    st_d.rxd.mixer_reader_en = (st_d.rx.mixer == `RFC_MIX_RD);
    st_d.rxd.mixer_card_en = (st_d.rx.mixer == `RFC_MIX_CD);
    st_d.rxd.hpc = st_d.rx.hpc;
    st_d.rxd.gain = st_d.rx.gain;
    st_d.rxd.miller = st_d.rx.miller;
  end

  //////////////////////////////////////////////////////////////////
  // state register

  // all configuration resets to zero
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign o_rdata = st_q.rdata;
  assign o_tx = st_q.txd;
  assign o_rx = st_q.rxd;

  //////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  // bus steps
  sequence s_wr_tx;
    i_wr && (i_addr == TX_ADDR);
  endsequence
  sequence s_wr_ck;
    i_wr && (i_addr == CK_ADDR);
  endsequence
  sequence s_wr_rx;
    i_wr && (i_addr == RX_ADDR);
  endsequence
  sequence s_rd_tx;
    i_rd && !i_wr && (i_addr == TX_ADDR);
  endsequence

  a_driver_select: assert property (
    s_wr_tx |=> o_tx.single_driver == $past(i_wdata[`RFC_TX_DRV]))
    else $error("driver select not taken from write");

  a_card_amplitude: assert property (
    s_wr_tx ##1 !o_tx.card_max
      |-> o_tx.card_amp == $past(i_wdata[`RFC_TX_AMP +: 2]))
    else $error("card amplitude not taken from write");

  a_prev_residual: assert property (
    $past(i_mode.prevention) |-> o_tx.residual == st_q.tx.prev_resid)
    else $error("prevention residual not applied");

  a_max_override: assert property (
    s_wr_tx ##1 $past(i_wdata[`RFC_TX_MAX])
      |-> o_tx.card_max && (o_tx.card_amp == 2'h0))
    else $error("max output does not override amplitude");

  a_residual_code: assert property (
    !$past(i_mode.prevention) |-> o_tx.residual == st_q.tx.resid)
    else $error("residual code altered");

  a_bypass_rise: assert property (
    o_tx.shaping_bypass |-> !o_tx.rise_tau_en)
    else $error("rising time constant active under bypass");

  a_slew_write: assert property (
    s_wr_tx |=> o_tx.slew == $past(i_wdata[`RFC_TX_SLW +: 4]))
    else $error("slew not taken from write");

  a_tau_pump: assert property (
    o_tx.fall_tau_en == $past(i_mode.single_pump))
    else $error("fall time constant gate wrong");

  a_active_lm: assert property (
    s_wr_ck ##1 $past(i_wdata[`RFC_CK_ALM]) && $past(i_mode.card_mode)
      |-> o_tx.active_loadmod)
    else $error("active load modulation not enabled");

  a_phase_write: assert property (
    s_wr_ck |=> o_tx.phase == $past(i_wdata[`RFC_CK_PH +: 3]))
    else $error("phase not taken from write");

  a_clk_prevent: assert property (
    s_wr_ck ##1 $past(i_mode.prevention)
      |-> o_tx.clk_mode == $past(i_wdata[`RFC_CK_PRV +: 3]))
    else $error("prevention clock mode not applied");

  a_invert_reader: assert property (
    !$past(i_mode.card_mode)
      |-> (o_tx.out1_invert == st_q.ck.inv1_rd)
       && (o_tx.out2_invert == st_q.ck.inv2_rd))
    else $error("reader inversion wrong");

  a_invert_card: assert property (
    $past(i_mode.card_mode)
      |-> (o_tx.out1_invert == st_q.ck.inv1_cd)
       && (o_tx.out2_invert == st_q.ck.inv2_cd))
    else $error("card inversion wrong");

  a_reader_mode: assert property (
    s_wr_ck ##1 !$past(i_mode.prevention)
      |-> o_tx.clk_mode == $past(i_wdata[`RFC_CK_RMD +: 3]))
    else $error("reader clock mode not applied");

  a_mixer_decode: assert property (
    s_wr_rx |=> (o_rx.mixer_reader_en
                 == ($past(i_wdata[`RFC_RX_MIX +: 2]) == 2'h1))
             && (o_rx.mixer_card_en
                 == ($past(i_wdata[`RFC_RX_MIX +: 2]) == 2'h2)))
    else $error("mixer decode wrong");

  a_corner_write: assert property (
    s_wr_rx |=> o_rx.hpc == $past(i_wdata[`RFC_RX_HPC +: 2]))
    else $error("corner not taken from write");

  a_gain_write: assert property (
    s_wr_rx |=> o_rx.gain == $past(i_wdata[`RFC_RX_GN +: 2]))
    else $error("gain not taken from write");

  a_miller_write: assert property (
    s_wr_rx |=> o_rx.miller == $past(i_wdata[`RFC_RX_MIL +: 2]))
    else $error("miller level not taken from write");

  a_reserved_zero: assert property (
    s_rd_tx |=> o_rdata[31:27] == 5'h0)
    else $error("reserved bits read nonzero");

  a_read_once: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside read slot");

endmodule : rfc_regs

`default_nettype wire

// File: sim/rfc_analog_model.sv
/*
  rfc_analog_model.sv: behavioural analog receiver and transmitter
  clock path, fed by the settings of the register bank.
  assumes: settings are levels on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none

module rfc_analog_model (
  input wire rfc_pkg::rfc_txdrv_t i_tx, // transmitter settings
  input wire rfc_pkg::rfc_rxdrv_t i_rx, // receiver settings
  output logic [7:0] o_gain_db, // baseband gain in dB
  output logic [8:0] o_corner_khz, // high-pass corner in kHz
  output logic [1:0] o_clk_inv // 1 = output uses inverted carrier
);
  //////////////////////////////////////////////////////////////////
  localparam logic [7:0] GAIN_TAB [4] = '{8'h21, 8'h28, 8'h32, 8'h39};
  localparam logic [8:0] HPC_TAB [4] = '{9'h02d, 9'h055, 9'h096, 9'h0fa};

  // receiver chain gain and corner, transmitter clock choice
  assign o_gain_db = GAIN_TAB[i_rx.gain];
  assign o_corner_khz = HPC_TAB[i_rx.hpc];
  assign o_clk_inv = {i_tx.out2_invert, i_tx.out1_invert};
endmodule : rfc_analog_model

`default_nettype wire

// File: sim/tb_rf_frontend_control_regs.sv
/*
  tb_rf_frontend_control_regs.sv: self-checking bench of rfc_regs.
  assumes: 100 MHz clock, reset held two cycles at the start.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_rf_frontend_control_regs;
  typedef struct packed {
    logic [9:0] a;
    logic [31:0] d;
    logic [2:0] m;
  } rfc_row_t;
  logic i_clk_sys, i_reset, i_wr, i_rd;
  logic [9:0] i_addr;
  logic [31:0] i_wdata, o_rdata, q;
  rfc_pkg::rfc_mode_t i_mode;
  rfc_pkg::rfc_txdrv_t o_tx;
  rfc_pkg::rfc_rxdrv_t o_rx;
  logic [7:0] gain_db;
  logic [8:0] corner_khz;
  logic [1:0] clk_inv;
  int miscompares, total_checks;
  logic [31:0] sh [3];
  // address, write data, mode {card, prevention, single pump}
  localparam rfc_row_t ROWS [12] = '{
    '{10'h080, 32'hffff_ffff, 3'h0}, '{10'h084, 32'hffff_ffff, 3'h4},
    '{10'h088, 32'hffff_ffff, 3'h1}, '{10'h080, 32'h0555_5555, 3'h3},
    '{10'h084, 32'h0001_2a5a, 3'h6}, '{10'h080, 32'h0304_1aa5, 3'h1},
    '{10'h088, 32'h0000_0019, 3'h0}, '{10'h088, 32'h0000_0026, 3'h4},
    '{10'h088, 32'h0000_0000, 3'h2}, '{10'h08c, 32'h1234_5678, 3'h0},
    '{10'h082, 32'h0000_00ff, 3'h0}, '{10'h000, 32'hffff_ffff, 3'h7}};

  rfc_regs dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_mode(i_mode),
    .o_rdata(o_rdata), .o_tx(o_tx), .o_rx(o_rx));
  rfc_analog_model far (.i_tx(o_tx), .i_rx(o_rx), .o_gain_db(gain_db),
    .o_corner_khz(corner_khz), .o_clk_inv(clk_inv));

  //////////////////////////////////////////////////////////////////
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task automatic report_and_stop;
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk_word(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  // expected settings from the shadow registers and the mode
  function automatic rfc_pkg::rfc_txdrv_t exp_tx();
    rfc_pkg::rfc_tx_t t;
    rfc_pkg::rfc_ck_t c;
    rfc_pkg::rfc_txdrv_t e;
    t = sh[0][26:0];
    c = {sh[1][18], sh[1][13:0]};
    e.single_driver = t.drv_single;
    e.card_amp = t.card_max ? 2'h0 : t.card_amp;
    e.card_max = t.card_max;
    e.residual = i_mode.prevention ? t.prev_resid : t.resid;
    e.shaping_bypass = t.bypass;
    e.slew = t.slew;
    e.fall_tau = t.tau_fall;
    e.fall_tau_en = i_mode.single_pump;
    e.rise_tau = t.tau_rise;
    e.rise_tau_en = i_mode.single_pump & ~t.bypass;
    e.active_loadmod = c.active_load_modulation & i_mode.card_mode;
    e.phase = c.phase;
    e.clk_mode = i_mode.prevention ? c.prev_mode : c.rd_mode;
    e.out1_invert = i_mode.card_mode ? c.inv1_cd : c.inv1_rd;
    e.out2_invert = i_mode.card_mode ? c.inv2_cd : c.inv2_rd;
    e.pll_enable = c.pll;
    return e;
  endfunction : exp_tx

  task automatic chk_drv;
    rfc_pkg::rfc_rx_t r;
    rfc_pkg::rfc_rxdrv_t e;
    rfc_pkg::rfc_txdrv_t x;
    logic [7:0] g [4];
    logic [8:0] h [4];
    x = exp_tx();
    g = '{8'h21, 8'h28, 8'h32, 8'h39};
    h = '{9'h02d, 9'h055, 9'h096, 9'h0fa};
    r = sh[2][7:0];
    e = {r.mixer == 2'h1, r.mixer == 2'h2, r.hpc, r.gain, r.miller};
    total_checks++;
    if ({o_tx, o_rx, gain_db, corner_khz, clk_inv} !==
        {x, e, g[r.gain], h[r.hpc], x.out2_invert, x.out1_invert}) begin
      miscompares++;
      $display("[FAIL] %0t settings %h %h", $time, o_tx, o_rx);
    end
  endtask : chk_drv

  // one-cycle strobes, signals changed right after a rising edge
  task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    case (a)
      10'h080: sh[0] = d & 32'h07ff_ffff;
      10'h084: sh[1] = d & 32'h0004_3fff;
      10'h088: sh[2] = d & 32'h0000_00ff;
      default: ;
    endcase
  endtask : bus_wr

  task automatic bus_rd(input logic [9:0] a, output logic [31:0] v);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : bus_rd

  function automatic logic [31:0] exp_rd(input logic [9:0] a);
    case (a)
      10'h080: return sh[0];
      10'h084: return sh[1];
      10'h088: return sh[2];
      default: return 32'h0000_0000;
    endcase
  endfunction : exp_rd

  //////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    {i_reset, i_wr, i_rd, i_addr, i_wdata, i_mode} = '0;
    i_reset = 1'b1;
    miscompares = 0;
    total_checks = 0;
    sh = '{default: 32'h0000_0000};
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    #1 chk_drv();
    // table of writes, mode changes and read backs
    foreach (ROWS[k]) begin
      bus_wr(ROWS[k].a, ROWS[k].d);
      i_mode <= ROWS[k].m;
      @(posedge i_clk_sys);
      bus_rd(ROWS[k].a, q);
      chk_word(q, exp_rd(ROWS[k].a));
      chk_drv();
    end
    // write then read with no gap, mode change taken one cycle later
    @(posedge i_clk_sys);
    bus_wr(10'h088, 32'hffff_ff96);
    i_rd <= 1'b1;
    i_mode <= 3'h5;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk_word(o_rdata, 32'h0000_0096);
    chk_drv();
    @(posedge i_clk_sys);
    #1 chk_word(o_rdata, 32'h0000_0000);
    // reset in mid-run clears every register
    @(posedge i_clk_sys);
    i_mode <= 3'h0;
    i_reset <= 1'b1;
    sh = '{default: 32'h0000_0000};
    @(posedge i_clk_sys);
    #1 chk_drv();
    @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    bus_rd(10'h088, q);
    chk_word(q, 32'h0000_0000);
    report_and_stop();
  end
endmodule : tb_rf_frontend_control_regs

`default_nettype wire
